// ---- design/codec_port_device.sv ----
`default_nettype none
// Behaviour
// R01: 3-wire: shift one data bit per clock rise
// R02: select-pin rise commits last sixteen data bits
// R03: leading read bit makes device drive data
// R04: readback: part id at 0, revision at 1
// R05: 2-wire: target only, own 7-bit address
// R06: data fall with clock high starts transfer
// R07: after start take address and direction, MSB first
// R08: matching address acknowledged by pulling data low
// R09: mismatch or read request: no ack, idle
// R10: write is register byte then two data bytes
// R11: data rise with clock high ends transfer
// R12: stray start or stop abandons current transfer
// R13: fixed target address 0011010
// R14: any write to address 0 restores defaults
// R15: power-on reset loads all register defaults
// R16: host resets by software at power up/down
// R17: 24-bit word: register byte, sixteen data bits
// R18: mode pin low 2-wire, else 3-wire; the GPIO override bit also forces 3-wire with the pin low
// R19: auto-increment writes, enable defaults to one
// R20: 3-wire readback shifts sixteen bits MSB first
module codec_port_device (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    codec_ctrl_if.device link,
    output logic wr_strobe_o,
    output logic [6:0] wr_addr_o,
    output logic [15:0] wr_data_o,
    output logic soft_reset_o,
    output logic three_wire_o
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_ACK = 5'b00100,
        ST_BYTE = 5'b01000,
        ST_TW = 5'b10000
    } dev_st_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0] csb_s;
        logic [1:0] mode_s;
        dev_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [1:0] idx;
        logic rd;
        logic [4:0] dcnt;
        logic [6:0] addr;
        logic [15:0] data;
        logic sda_out;
        logic sda_oe_n;
        logic [codec_ctrl_pkg::NUM_REGS-1:0][15:0] regs;
        logic wr;
        logic [6:0] wa;
        logic [15:0] wd;
        logic srst;
        logic tw;
    } dev_state_t;

    dev_state_t q, d;

    // ------------------------------------------------------------
    // readback decode
    // ------------------------------------------------------------
    function automatic logic [15:0] read_word(input logic [6:0] a);
        read_word = '0;
        if (a == codec_ctrl_pkg::REG_RESET_PART_ID) begin
            read_word = codec_ctrl_pkg::PART_ID_VAL; // R04
        end else if (a == codec_ctrl_pkg::REG_POWER_REV) begin
            read_word = {13'h0000, codec_ctrl_pkg::REVISION_VAL}; // R04
        end
    endfunction : read_word

    function automatic logic readable(input logic [6:0] a);
        readable = a <= codec_ctrl_pkg::REG_POWER_REV;
    endfunction : readable

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic sda;
        logic start;
        logic stop;
        logic csb_rise;
        logic auto_inc;
        logic we;
        logic [6:0] wa_c;
        logic [15:0] wd_c;
        logic [7:0] byte_in;
        d = q;
        // first stage feeds only the second; [2] is the edge history
        d.scl_s = {q.scl_s[1], q.scl_s[0], link.sclk};
        d.sda_s = {q.sda_s[1], q.sda_s[0], link.sda_level};
        d.csb_s = {q.csb_s[1], q.csb_s[0], link.csb};
        d.mode_s = {q.mode_s[0], link.mode};
        d.wr = 1'b0;
        d.srst = 1'b0;
        rise = q.scl_s[1] & ~q.scl_s[2];
        fall = ~q.scl_s[1] & q.scl_s[2];
        sda = q.sda_s[1];
        start = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2];
        stop = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2];
        csb_rise = q.csb_s[1] & ~q.csb_s[2];
        auto_inc = q.regs[codec_ctrl_pkg::REG_IFACE][
            codec_ctrl_pkg::ADDR_AUTO_INC_BIT];
        we = 1'b0;
        wa_c = q.addr;
        wd_c = q.data;
        byte_in = {q.sh[6:0], sda};
        // gpio override forces 3-wire whatever the pin says
        d.tw = q.mode_s[1] | q.regs[codec_ctrl_pkg::REG_GPIO][
            codec_ctrl_pkg::MODE_GPIO_BIT]; // R18
        if (d.tw) begin
            if (q.st != ST_TW) begin
                d.st = ST_IDLE;
                d.sda_oe_n = 1'b1;
                if (!q.csb_s[1]) begin
                    d.st = ST_TW;
                    d.cnt = '0;
                    d.dcnt = '0;
                    d.rd = 1'b0;
                    d.data = '0;
                end
            end else if (csb_rise) begin
                d.st = ST_IDLE;
                d.sda_oe_n = 1'b1; // R03
                we = !q.rd && q.dcnt == codec_ctrl_pkg::WORD_BITS; // R02
            end else if (rise && q.cnt != codec_ctrl_pkg::BYTE_BITS) begin
                d.sh = byte_in; // R01
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == codec_ctrl_pkg::BYTE_BITS - 4'h1) begin
                    d.rd = byte_in[7]; // R03
                    d.addr = byte_in[6:0]; // R17
                    d.data = read_word(byte_in[6:0]);
                end
            end else if (rise && !q.rd) begin
                d.data = {q.data[14:0], sda}; // R01
                if (q.dcnt != codec_ctrl_pkg::WORD_BITS) begin
                    d.dcnt = q.dcnt + 5'h01;
                end else if (auto_inc) begin
                    we = 1'b1; // R19
                    d.addr = q.addr + 7'h01;
                    d.dcnt = 5'h01;
                end
            end else if (fall && q.rd && q.cnt == codec_ctrl_pkg::BYTE_BITS) begin
                d.sda_oe_n = 1'b1;
                if (q.dcnt != codec_ctrl_pkg::WORD_BITS && readable(q.addr)) begin
                    d.sda_oe_n = 1'b0; // R20
                    d.sda_out = q.data[15];
                    d.data = {q.data[14:0], 1'b0};
                    d.dcnt = q.dcnt + 5'h01;
                end
            end
        end else if (start) begin
            d.st = ST_ADDR; // R06 R12
            d.cnt = '0;
            d.sda_oe_n = 1'b1;
        end else if (stop) begin
            d.st = ST_IDLE; // R11 R12
            d.sda_oe_n = 1'b1;
        end else begin
            unique case (q.st)
                ST_ADDR, ST_BYTE: begin
                    if (rise) begin
                        d.sh = byte_in; // R07
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt == codec_ctrl_pkg::BYTE_BITS - 4'h1) begin
                            d.st = ST_ACK;
                            if (q.st == ST_ADDR) begin
                                d.idx = 2'h0;
                                if (byte_in[7:1] != codec_ctrl_pkg::TARGET_ADDR
                                    || byte_in[0]) begin
                                    d.st = ST_IDLE; // R05 R09 R13
                                end
                            end else if (q.idx == 2'h0) begin
                                d.addr = byte_in[6:0]; // R10
                                d.idx = 2'h1;
                            end else if (q.idx == 2'h1) begin
                                d.data = {byte_in, q.data[7:0]}; // R10
                                d.idx = 2'h2;
                            end else begin
                                we = 1'b1; // R10
                                wd_c = {q.data[15:8], byte_in};
                                d.idx = 2'h1;
                                if (auto_inc) begin
                                    d.addr = q.addr + 7'h01; // R19
                                end
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (fall && q.sda_oe_n) begin
                        d.sda_oe_n = 1'b0; // R08
                        d.sda_out = 1'b0;
                    end else if (fall) begin
                        d.sda_oe_n = 1'b1;
                        d.st = ST_BYTE;
                        d.cnt = '0;
                    end
                end
                ST_IDLE, ST_TW: begin
                    d.st = ST_IDLE;
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end
        // ------------------------------------------------------------
        // register write
        // ------------------------------------------------------------
        if (we) begin
            d.wr = 1'b1;
            d.wa = wa_c;
            d.wd = wd_c;
            if (wa_c == codec_ctrl_pkg::REG_RESET_PART_ID) begin
                d.regs = codec_ctrl_pkg::REG_DEFAULTS; // R14
                d.srst = 1'b1;
            end else if (wa_c < 7'(codec_ctrl_pkg::NUM_REGS)) begin
                d.regs[wa_c[3:0]] = wd_c;
                // the override would cut a 2-wire host off its own port
                if (!q.tw && wa_c == codec_ctrl_pkg::REG_GPIO) begin
                    d.regs[wa_c[3:0]][codec_ctrl_pkg::MODE_GPIO_BIT] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.scl_s <= 3'h7;
            q.sda_s <= 3'h7;
            q.csb_s <= 3'h7;
            q.mode_s <= 2'h3;
            q.sda_out <= 1'b1;
            q.sda_oe_n <= 1'b1;
            q.regs <= codec_ctrl_pkg::REG_DEFAULTS; // R15
            q.tw <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign wr_strobe_o = q.wr;
    assign wr_addr_o = q.wa;
    assign wr_data_o = q.wd;
    assign soft_reset_o = q.srst;
    assign three_wire_o = q.tw;
    assign link.dev_sda_out = q.sda_out;
    assign link.dev_sda_oe_n = q.sda_oe_n;
endmodule : codec_port_device
`default_nettype wire

// ---- design/codec_ctrl_pkg.sv ----
`default_nettype none
package codec_ctrl_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SCLK_PERIOD_NS = 800;
    localparam logic [2:0] SCLK_HALF_CYC =
        3'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));

    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h1A;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam logic [5:0] FRAME_BITS_3W = 6'h18;
    localparam logic [5:0] FRAME_BITS_2W = 6'h24;
    localparam logic [5:0] SLOT_BITS_2W = 6'h09;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned NUM_REGS = 10;
    localparam logic [6:0] REG_RESET_PART_ID = 7'h00;
    localparam logic [6:0] REG_POWER_REV = 7'h01;
    localparam logic [6:0] REG_GPIO = 7'h08;
    localparam logic [6:0] REG_IFACE = 7'h09;
    localparam int unsigned MODE_GPIO_BIT = 7;
    localparam int unsigned ADDR_AUTO_INC_BIT = 1;
    // arbitrary identity values
    localparam logic [15:0] PART_ID_VAL = 16'h5A5A;
    localparam logic [2:0] REVISION_VAL = 3'h1;
    localparam logic [NUM_REGS-1:0][15:0] REG_DEFAULTS = {
        16'h0002, 16'h0000, 16'h0000, 16'h0140, 16'h0000,
        16'h0050, 16'h0000, 16'h0000, 16'h0000, 16'h0000
    };
endpackage : codec_ctrl_pkg
`default_nettype wire

// ---- design/codec_ctrl_if.sv ----
`default_nettype none
interface codec_ctrl_if;
    logic sclk;
    logic csb;
    logic mode;
    logic host_sda_out;
    logic host_sda_oe_n;
    logic dev_sda_out;
    logic dev_sda_oe_n;
    logic sda_level;

    // released line is pulled high; either end may pull it
    assign sda_level = (host_sda_oe_n | host_sda_out)
                     & (dev_sda_oe_n | dev_sda_out);

    modport host (
        output sclk,
        output csb,
        output mode,
        output host_sda_out,
        output host_sda_oe_n,
        input sda_level
    );
    modport device (
        input sclk,
        input csb,
        input mode,
        input sda_level,
        output dev_sda_out,
        output dev_sda_oe_n
    );
endinterface : codec_ctrl_if
`default_nettype wire

// ---- design/codec_port_host.sv ----
`default_nettype none
module codec_port_host (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic two_wire_i,
    input wire logic read_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [15:0] wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic nack_o,
    output logic [15:0] rdata_o,
    codec_ctrl_if.host link
);
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_START = 5'b00010,
        H_BIT = 5'b00100,
        H_STOP = 5'b01000,
        H_END = 5'b10000
    } host_st_t;

    typedef struct packed {
        logic [1:0] sda_s;
        host_st_t st;
        logic [2:0] div;
        logic ph;
        logic [5:0] bitn;
        logic [35:0] tx;
        logic two_w;
        logic rd;
        logic [15:0] rx;
        logic nack;
        logic scl;
        logic csb;
        logic mode;
        logic sda_out;
        logic sda_oe_n;
        logic busy;
        logic done;
        logic [15:0] rdata;
    } host_state_t;

    host_state_t q, d;

    // ------------------------------------------------------------
    // slots where the far end owns the data line
    // ------------------------------------------------------------
    function automatic logic released(input logic [5:0] pos,
                                      input logic two_w,
                                      input logic rd);
        if (two_w) begin
            released = (pos % codec_ctrl_pkg::SLOT_BITS_2W) ==
                       (codec_ctrl_pkg::SLOT_BITS_2W - 6'h01);
        end else begin
            released = rd && (pos >= 6'(codec_ctrl_pkg::BYTE_BITS));
        end
    endfunction : released

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic tick;
        logic [5:0] pos;
        logic [5:0] nbits;
        tick = 1'b0;
        pos = '0;
        nbits = '0;
        d = q;
        d.done = 1'b0;
        d.sda_s = {q.sda_s[0], link.sda_level};
        tick = q.div == codec_ctrl_pkg::SCLK_HALF_CYC - 3'h1;
        d.div = tick ? 3'h0 : q.div + 3'h1;
        pos = q.bitn - 6'h01;
        nbits = q.two_w ? codec_ctrl_pkg::FRAME_BITS_2W
                        : codec_ctrl_pkg::FRAME_BITS_3W;
        unique case (q.st)
            H_IDLE: begin
                if (req_i) begin
                    d.st = H_START;
                    d.busy = 1'b1;
                    d.two_w = two_wire_i;
                    d.rd = read_i & ~two_wire_i;
                    d.mode = ~two_wire_i; // R18
                    d.nack = 1'b0;
                    d.rx = '0;
                    d.bitn = '0;
                    d.ph = 1'b0;
                    d.div = 3'h0;
                    // ack slots carry a 1 so the line is left free
                    if (two_wire_i) begin
                        d.tx = {codec_ctrl_pkg::TARGET_ADDR, 1'b0, 1'b1,
                                1'b0, reg_addr_i, 1'b1,
                                wdata_i[15:8], 1'b1,
                                wdata_i[7:0], 1'b1}; // R10 R17
                    end else begin
                        d.tx = {read_i, reg_addr_i, wdata_i,
                                12'h000}; // R03 R17
                    end
                end
            end
            H_START: begin
                if (tick) begin
                    d.st = H_BIT;
                    if (q.two_w) begin
                        d.sda_oe_n = 1'b0; // R06
                        d.sda_out = 1'b0;
                    end else begin
                        d.csb = 1'b0;
                    end
                end
            end
            H_BIT: begin
                if (tick && q.ph) begin
                    d.scl = 1'b1;
                    d.ph = 1'b0;
                    d.bitn = q.bitn + 6'h01;
                end else if (tick) begin
                    if (q.bitn != 6'h00 && released(pos, q.two_w, q.rd)) begin
                        if (q.two_w) begin
                            d.nack = q.nack | q.sda_s[1];
                        end else begin
                            d.rx = {q.rx[14:0], q.sda_s[1]};
                        end
                    end
                    d.scl = 1'b0;
                    if (q.bitn == nbits) begin
                        d.st = q.two_w ? H_STOP : H_END;
                        // data released in 3-wire, held low in 2-wire for the stop
                        d.sda_oe_n = ~q.two_w;
                        // 3-wire keeps the clock high: no extra edge
                        d.scl = ~q.two_w;
                    end else begin
                        d.ph = 1'b1;
                        d.tx = {q.tx[34:0], 1'b0};
                        d.sda_out = q.two_w ? 1'b0 : q.tx[35];
                        if (released(q.bitn, q.two_w, q.rd)) begin
                            d.sda_oe_n = 1'b1; // R03
                        end else begin
                            d.sda_oe_n = q.two_w & q.tx[35];
                        end
                    end
                end
            end
            H_STOP: begin
                if (tick) begin
                    d.scl = 1'b1;
                    d.st = H_END;
                end
            end
            H_END: begin
                if (tick) begin
                    d.sda_oe_n = 1'b1; // R11
                    d.csb = 1'b1; // R02
                    d.st = H_IDLE;
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.rdata = q.rx;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.st <= H_IDLE;
            q.sda_s <= 2'h3;
            q.scl <= 1'b1;
            q.csb <= 1'b1;
            q.mode <= 1'b1;
            q.sda_out <= 1'b1;
            q.sda_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign busy_o = q.busy;
    assign done_o = q.done;
    assign nack_o = q.nack;
    assign rdata_o = q.rdata;
    assign link.sclk = q.scl;
    assign link.csb = q.csb;
    assign link.mode = q.mode;
    assign link.host_sda_out = q.sda_out;
    assign link.host_sda_oe_n = q.sda_oe_n;
endmodule : codec_port_host
`default_nettype wire

// ---- bench/codec_link_properties.sv ----
`default_nettype none
module codec_link_properties (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic sclk,
    input wire logic csb,
    input wire logic mode,
    input wire logic host_sda_out,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe_n,
    input wire logic sda_level
);
    // ------------------------------------------------------------
    // helper state: clock rises counted since frame start
    // ------------------------------------------------------------
    logic sclk_q;
    logic sda_q;
    logic [5:0] cnt_q;
    logic hi_hold;
    logic start_seen;
    logic stop_seen;
    assign hi_hold = sclk & sclk_q;
    assign start_seen = hi_hold & sda_q & ~sda_level;
    assign stop_seen = hi_hold & ~sda_q & sda_level;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b1;
            sda_q <= 1'b1;
            cnt_q <= 6'h00;
        end else begin
            sclk_q <= sclk;
            sda_q <= sda_level;
            if (mode ? csb : start_seen) begin
                cnt_q <= 6'h00;
            end else if (sclk & ~sclk_q) begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    frame3_len_a: assert property (mode && $rose(csb) |->
        cnt_q == codec_ctrl_pkg::FRAME_BITS_3W) else $error("3w frame len");
    host_bit_steady_a: assert property (mode && !csb && hi_hold
        |-> $stable(host_sda_out)) else $error("3w data moved");
    rd_drive_start_a: assert property (mode && $fell(dev_sda_oe_n)
        |-> !csb && cnt_q == 6'h08) else $error("3w drive start");
    rd_release_a: assert property (mode && $rose(csb)
        |-> ##[0:5] dev_sda_oe_n) else $error("3w no release");
    ack_slot_low_a: assert property (!mode && sclk && !sclk_q
        && cnt_q >= 6'h08
        && ((cnt_q + 6'h01) % codec_ctrl_pkg::SLOT_BITS_2W) == 6'h00
        |-> !sda_level) else $error("2w ack missing");
    open_drain_a: assert property (!mode && !dev_sda_oe_n
        |-> !dev_sda_out) else $error("2w drove high");
    dev_sda_steady_a: assert property (!mode && hi_hold
        |-> $stable(dev_sda_oe_n)) else $error("2w device moved");
    // stop needs one more clock pulse after the last ack
    frame2_len_a: assert property (!mode && stop_seen
        |-> cnt_q == codec_ctrl_pkg::FRAME_BITS_2W + 6'h01)
        else $error("2w frame len");
    edge_at_bounds_a: assert property (!mode && hi_hold
        && sda_level != sda_q
        |-> cnt_q == 6'h00
            || cnt_q == codec_ctrl_pkg::FRAME_BITS_2W + 6'h01)
        else $error("2w stray edge");
    cover property (mode && $rose(csb));
    cover property (mode && $fell(dev_sda_oe_n));
    cover property (!mode && stop_seen);
endmodule : codec_link_properties
`default_nettype wire

// ---- bench/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req = 1'b0;
    logic two_wire = 1'b0;
    logic read = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [15:0] wdata = 16'h0000;
    logic busy, done, nack, wr_strobe, soft_reset, three_wire;
    logic [15:0] rdata, wr_data;
    logic [6:0] wr_addr;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_wr = 0;
    int n_srst = 0;
    logic last_tw;
    codec_ctrl_if link_if ();
    codec_port_host codec_port_host_inst (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .req_i(req), .two_wire_i(two_wire),
        .read_i(read), .reg_addr_i(reg_addr), .wdata_i(wdata),
        .busy_o(busy), .done_o(done), .nack_o(nack), .rdata_o(rdata),
        .link(link_if));
    codec_port_device codec_port_device_inst (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .link(link_if), .wr_strobe_o(wr_strobe),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .soft_reset_o(soft_reset), .three_wire_o(three_wire));
    codec_link_properties codec_link_properties_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sclk(link_if.sclk),
        .csb(link_if.csb), .mode(link_if.mode),
        .host_sda_out(link_if.host_sda_out),
        .host_sda_oe_n(link_if.host_sda_oe_n),
        .dev_sda_out(link_if.dev_sda_out),
        .dev_sda_oe_n(link_if.dev_sda_oe_n),
        .sda_level(link_if.sda_level));
    always #50 sys_clk_i = ~sys_clk_i;
    // ------------------------------------------------------------
    // device user-side monitor
    // ------------------------------------------------------------
    always @(negedge sys_clk_i) begin
        if (wr_strobe === 1'b1) begin
            n_wr++;
            last_tw = three_wire;
        end
        if (soft_reset === 1'b1) begin
            n_srst++;
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask : chk
    // one whole host transfer; req held until busy is seen
    task automatic xfer(input logic tw, input logic rd,
                        input logic [6:0] a, input logic [15:0] d);
        int i;
        @(negedge sys_clk_i);
        two_wire = tw;
        read = rd;
        reg_addr = a;
        wdata = d;
        req = 1'b1;
        for (i = 0; i < 8 && busy !== 1'b1; i++) @(negedge sys_clk_i);
        req = 1'b0;
        for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge sys_clk_i);
        if (done !== 1'b1) begin
            $display("BAD done expected 1 seen %b", done);
            n_mismatch++;
            conclude();
        end
        // device commits a 3-wire word only after the latch edge
        repeat (6) @(negedge sys_clk_i);
    endtask : xfer
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_after_reset();
        chk("three_wire", 16'h0001, {15'h0000, three_wire});
        chk("dev_oe_n", 16'h0001, {15'h0000, link_if.dev_sda_oe_n});
    endtask : t_after_reset
    task automatic t_3w_write_pair();
        int n0;
        n0 = n_wr;
        xfer(1'b0, 1'b0, 7'h05, 16'h1234);
        chk("wr_data", 16'h1234, wr_data);
        xfer(1'b0, 1'b0, 7'h06, 16'hA5C3);
        chk("wr_addr", 16'h0006, {9'h000, wr_addr});
        chk("wr_data", 16'hA5C3, wr_data);
        chk("n_wr", 16'h0002, 16'(n_wr - n0));
        chk("mode", 16'h0001, {15'h0000, last_tw});
    endtask : t_3w_write_pair
    task automatic t_3w_read();
        logic [6:0] adr [3] = '{7'h00, 7'h01, 7'h05};
        logic [15:0] exp [3];
        int n0;
        exp = '{codec_ctrl_pkg::PART_ID_VAL,
                {13'h0000, codec_ctrl_pkg::REVISION_VAL}, 16'hFFFF};
        n0 = n_wr;
        for (int k = 0; k < 3; k++) begin
            xfer(1'b0, 1'b1, adr[k], 16'h0F0F);
            chk("rdata", exp[k], rdata);
        end
        chk("n_wr", 16'h0000, 16'(n_wr - n0));
    endtask : t_3w_read
    task automatic t_2w_write();
        xfer(1'b1, 1'b0, 7'h07, 16'hBEEF);
        chk("nack", 16'h0000, {15'h0000, nack});
        chk("wr_addr", 16'h0007, {9'h000, wr_addr});
        chk("wr_data", 16'hBEEF, wr_data);
        chk("mode", 16'h0000, {15'h0000, last_tw});
    endtask : t_2w_write
    task automatic t_soft_reset();
        int n0;
        n0 = n_srst;
        xfer(1'b1, 1'b0, 7'h00, 16'h3C96);
        chk("n_srst", 16'h0001, 16'(n_srst - n0));
        xfer(1'b0, 1'b1, 7'h00, 16'h0000);
        chk("rdata", codec_ctrl_pkg::PART_ID_VAL, rdata);
    endtask : t_soft_reset
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        @(negedge sys_clk_i);
        t_after_reset();
        t_3w_write_pair();
        t_3w_read();
        t_2w_write();
        t_soft_reset();
        t_3w_write_pair();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
